/* core/spfb_pkg.sv */
// Constants and types shared by the serial port frame and baud control block
package spfb_pkg;
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_STAT_A = 3'h1;
  localparam logic [2:0] ADDR_CTRL_B = 3'h2;
  localparam logic [2:0] ADDR_CTRL_C = 3'h3;
  localparam logic [2:0] ADDR_BAUD_L = 3'h4;
  localparam logic [2:0] ADDR_BAUD_H = 3'h5;
  // Status A bit positions
  localparam int SA_RX_DONE = 7;
  localparam int SA_TX_DONE = 6;
  localparam int SA_TX_EMPTY = 5;
  localparam int SA_FRAME_ERR = 4;
  localparam int SA_OVERRUN = 3;
  localparam int SA_PARITY_ERR = 2;
  localparam int SA_DOUBLE = 1;
  // Control B bit positions
  localparam int CB_TX_IRQ_EN = 5;
  localparam int CB_RX_EN = 4;
  localparam int CB_TX_EN = 3;
  localparam int CB_SIZE2 = 2;
  localparam int CB_RX_NINTH = 1;
  localparam int CB_TX_NINTH = 0;
  // Control C bit positions
  localparam int CC_SYNC = 6;
  localparam int CC_PAR_HI = 5;
  localparam int CC_PAR_LO = 4;
  localparam int CC_STOP2 = 3;
  localparam int CC_SIZE_HI = 2;
  localparam int CC_SIZE_LO = 1;
  localparam int CC_POL = 0;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_C_RST = 8'h06;
  localparam logic [11:0] BAUD_RST = 12'h000;
  // Oversampling: last count and mid count per bit, normal and double speed
  localparam logic [3:0] OS_LAST_NORM = 4'hF;
  localparam logic [3:0] OS_LAST_DBL = 4'h7;
  localparam logic [3:0] OS_MID_NORM = 4'h7;
  localparam logic [3:0] OS_MID_DBL = 4'h3;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  localparam logic [3:0] MAX_BITS = 4'h9;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2}
    spfb_state_type;

  // Reserved size codes fall back to eight bits
  function automatic logic [3:0] spfb_bits(input logic [2:0] code);
    case (code)
      3'h0: spfb_bits = 4'h5;
      3'h1: spfb_bits = 4'h6;
      3'h2: spfb_bits = 4'h7;
      3'h7: spfb_bits = 4'h9;
      default: spfb_bits = 4'h8;
    endcase
  endfunction
endpackage

/* core/spfb_rx_if.sv */
// Link between the control block and its receiver
`timescale 1ns/1ps
interface spfb_rx_if;
  logic       rx_en;
  logic       sync_mode;
  logic       double_speed;
  logic [1:0] parity_mode;
  logic [3:0] nbits;
  logic       os_tick;
  logic       edge_tick;
  logic       rx_bit;
  logic       done;
  logic [8:0] data;
  logic       fe;
  logic       pe;
  modport ctl (output rx_en, sync_mode, double_speed, parity_mode, nbits, os_tick,
               edge_tick, rx_bit, input done, data, fe, pe);
  modport rx (input rx_en, sync_mode, double_speed, parity_mode, nbits, os_tick,
              edge_tick, rx_bit, output done, data, fe, pe);
endinterface

/* core/spfb_baud.sv */
// Baud prescaler, transmit bit timing and synchronous clock generation
`timescale 1ns/1ps
module spfb_baud
  import spfb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [11:0] divisor,
  input  wire logic        reload,
  input  wire logic        sync_mode,
  input  wire logic        double_speed,
  input  wire logic        clk_pol,
  input  wire logic        run,
  output logic             os_tick,
  output logic             tx_tick,
  output logic             rx_edge,
  output logic             xck_reg
);
  logic [11:0] presc_reg;
  logic [3:0]  os_cnt_reg;
  logic        presc_zero;
  logic [3:0]  os_last;
  logic        xck_next;

  assign presc_zero = (presc_reg == 12'h000);
  assign os_last    = double_speed ? OS_LAST_DBL : OS_LAST_NORM; // [RQ19]
  assign xck_next   = (sync_mode && run) ? ~xck_reg : 1'b0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      presc_reg  <= 12'h000;
      os_cnt_reg <= 4'h0;
      xck_reg    <= 1'b0;
      os_tick    <= 1'b0;
      tx_tick    <= 1'b0;
      rx_edge    <= 1'b0;
    end else begin
      os_tick <= presc_zero;
      tx_tick <= 1'b0;
      rx_edge <= 1'b0;
      if (reload || presc_zero) begin
        presc_reg <= divisor; // [RQ16] [RQ21]
      end else begin
        presc_reg <= presc_reg - 12'h001;
      end
      if (presc_zero) begin
        os_cnt_reg <= (os_cnt_reg >= os_last) ? 4'h0 : os_cnt_reg + 4'h1;
        if (!sync_mode && os_cnt_reg >= os_last) begin
          tx_tick <= 1'b1; // [RQ21]
        end
        xck_reg <= xck_next;
        // Output changes on the edge set by polarity, input sampled on the other
        if (sync_mode && run) begin
          tx_tick <= (xck_next != clk_pol); // [RQ13]
          rx_edge <= (xck_next == clk_pol); // [RQ13]
        end
      end
    end
  end
endmodule // spfb_baud

/* core/spfb_rx.sv */
// Frame receiver with parity and stop checking
`timescale 1ns/1ps
module spfb_rx
  import spfb_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rstn,
  spfb_rx_if.rx     link
);
  spfb_state_type state_reg;
  logic [3:0] cnt_reg;
  logic [3:0] bits_reg;
  logic [8:0] sh_reg;
  logic       par_reg;
  logic [3:0] target;
  logic       sample;
  logic       calc_par;

  assign target = (state_reg == ST_START) ? (link.double_speed ? OS_MID_DBL : OS_MID_NORM)
                                          : (link.double_speed ? OS_LAST_DBL : OS_LAST_NORM);
  assign sample = link.sync_mode ? link.edge_tick : (link.os_tick && cnt_reg == target);
  assign calc_par = (^sh_reg) ^ link.parity_mode[0];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      bits_reg  <= 4'h0;
      sh_reg    <= 9'h000;
      par_reg   <= 1'b0;
      link.done <= 1'b0;
      link.data <= 9'h000;
      link.fe   <= 1'b0;
      link.pe   <= 1'b0;
    end else begin
      link.done <= 1'b0;
      if (link.os_tick) begin
        cnt_reg <= (cnt_reg == target) ? 4'h0 : cnt_reg + 4'h1;
      end
      if (!link.rx_en) begin
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            bits_reg <= 4'h0;
            sh_reg   <= 9'h000;
            if (!link.rx_bit && (!link.sync_mode || link.edge_tick)) begin
              state_reg <= link.sync_mode ? ST_DATA : ST_START;
              cnt_reg   <= 4'h0;
            end
          end
          ST_START: if (sample) begin
            state_reg <= link.rx_bit ? ST_IDLE : ST_DATA;
          end
          ST_DATA: if (sample) begin
            sh_reg   <= {link.rx_bit, sh_reg[8:1]};
            bits_reg <= bits_reg + 4'h1;
            if (bits_reg + 4'h1 == link.nbits) begin
              state_reg <= link.parity_mode[1] ? ST_PARITY : ST_STOP1;
            end
          end
          ST_PARITY: if (sample) begin
            par_reg   <= link.rx_bit;
            state_reg <= ST_STOP1;
          end
          ST_STOP1: if (sample) begin
            // Only one stop bit is checked, whatever the transmit setting
            link.done <= 1'b1; // [RQ12]
            link.data <= sh_reg >> (MAX_BITS - link.nbits); // [RQ6]
            link.fe   <= ~link.rx_bit;
            link.pe   <= link.parity_mode[1] && (par_reg != calc_par); // [RQ10] [RQ11]
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // spfb_rx

/* core/spfb_top.sv */
// Serial port control: registers, transmitter, receive buffer and pin takeover
// Summary of operation
// RQ1: Empty irq needs enable, global enable, flag
// RQ2: Receiver enable takes over receive pin
// RQ3: Receiver disable flushes buffer and error flags
// RQ4: Transmitter enable takes over transmit pin
// RQ5: Transmitter drains pending data before releasing pin
// RQ6: Size code selects 5 to 9 bits
// RQ7: Received ninth bit in its own field
// RQ8: Ninth transmit bit written before low byte
// RQ9: Mode bit selects asynchronous or synchronous
// RQ10: Parity generated on send, checked on receive
// RQ11: Parity field: off, reserved, even, odd
// RQ12: Stop select sets transmit stop count only
// RQ13: Clock polarity picks change and sample edges
// RQ14: Software keeps polarity zero in asynchronous mode
// RQ15: Twelve bit divisor split across two bytes
// RQ16: Low byte write reloads prescaler at once
// RQ17: Software avoids divisor change mid frame
// RQ18: Software writes zero to reserved baud bits
// RQ19: Double speed halves fixed divisor to eight
// RQ20: Empty flag set when buffer free, after reset
// RQ21: Bit rate is clock over sixteen times divisor+1
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module spfb_top
  import spfb_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       global_irq_enable,
  output logic            tx_empty_irq,
  input  wire logic       rxd_pin,
  output logic            rx_pin_owned,
  output logic            txd_out,
  output logic            txd_oe,
  output logic            sync_clock_pin_out,
  output logic            sync_clock_pin_oe
);
  import spfb_pkg::*;

  spfb_rx_if rxl ();

  logic [7:0]  ctrl_b_reg;
  logic [7:0]  ctrl_c_reg;
  logic [11:0] baud_divisor_reg;
  logic        double_speed_reg;
  logic        tx_done_reg;
  logic [8:0]  rx_buf_reg;
  logic        rx_full_reg;
  logic        fe_reg;
  logic        ovr_reg;
  logic        pe_reg;
  logic [8:0]  tx_buf_reg;
  logic        tx_full_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0]  tx_left_reg;
  logic        tx_busy_reg;
  logic        tx_active_reg;
  logic        rx_s1_reg;
  logic        rx_s2_reg;
  logic        os_tick;
  logic        tx_tick;
  logic        rx_edge;
  logic        sync_clock_pin;

  logic        wr_data;
  logic        wr_stat;
  logic        wr_ctrl_b;
  logic        wr_ctrl_c;
  logic        wr_baud_l;
  logic        wr_baud_h;
  logic        rd_data;
  logic        rx_en;
  logic        tx_en;
  logic        sync_mode;
  logic [1:0]  parity_mode;
  logic        stop2;
  logic [3:0]  nbits;
  logic [8:0]  mask;
  logic        tx_load;
  logic        tx_par;
  logic [3:0]  frame_len;
  logic        tx_end;
  logic [7:0]  stat_a;
  logic [7:0]  rd_mux;

  assign wr_data   = wr_stb && addr == ADDR_DATA;
  assign wr_stat   = wr_stb && addr == ADDR_STAT_A;
  assign wr_ctrl_b = wr_stb && addr == ADDR_CTRL_B;
  assign wr_ctrl_c = wr_stb && addr == ADDR_CTRL_C;
  assign wr_baud_l = wr_stb && addr == ADDR_BAUD_L;
  assign wr_baud_h = wr_stb && addr == ADDR_BAUD_H;
  assign rd_data   = rd_stb && addr == ADDR_DATA;

  assign rx_en       = ctrl_b_reg[CB_RX_EN];
  assign tx_en       = ctrl_b_reg[CB_TX_EN];
  assign sync_mode   = ctrl_c_reg[CC_SYNC]; // [RQ9]
  assign parity_mode = ctrl_c_reg[CC_PAR_HI:CC_PAR_LO];
  assign stop2       = ctrl_c_reg[CC_STOP2];
  assign nbits = spfb_bits({ctrl_b_reg[CB_SIZE2], ctrl_c_reg[CC_SIZE_HI:CC_SIZE_LO]}); // [RQ6]
  assign mask  = 9'h1FF >> (MAX_BITS - nbits);

  // Transmit: start bit, data, optional parity, one or two stops
  assign tx_load   = tx_full_reg && tx_active_reg && tx_tick && (!tx_busy_reg || tx_end);
  assign tx_par    = (^(tx_buf_reg & mask)) ^ parity_mode[0]; // [RQ10] [RQ11]
  assign frame_len = nbits + 4'h2 + {3'h0, parity_mode[1]} + {3'h0, stop2}; // [RQ12]
  assign tx_end    = tx_busy_reg && tx_tick && tx_left_reg == 4'h1;

  assign stat_a = {rx_full_reg, tx_done_reg, ~tx_full_reg, fe_reg, ovr_reg, pe_reg,
                   double_speed_reg, 1'b0}; // [RQ20]

  always_comb begin
    case (addr)
      ADDR_DATA:   rd_mux = rx_buf_reg[7:0];
      ADDR_STAT_A: rd_mux = stat_a;
      ADDR_CTRL_B: rd_mux = {ctrl_b_reg[7:2], rx_buf_reg[8], ctrl_b_reg[0]}; // [RQ7]
      ADDR_CTRL_C: rd_mux = {1'b0, ctrl_c_reg[6:0]};
      ADDR_BAUD_L: rd_mux = baud_divisor_reg[7:0];
      ADDR_BAUD_H: rd_mux = {4'h0, baud_divisor_reg[11:8]}; // [RQ15]
      default:     rd_mux = 8'h00;
    endcase
  end

  assign rxl.rx_en        = rx_en;
  assign rxl.sync_mode    = sync_mode;
  assign rxl.double_speed = double_speed_reg;
  assign rxl.parity_mode  = parity_mode;
  assign rxl.nbits        = nbits;
  assign rxl.os_tick      = os_tick;
  assign rxl.edge_tick    = rx_edge;
  assign rxl.rx_bit       = rx_s2_reg;

  spfb_baud u_baud (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .divisor      (wr_baud_l ? {baud_divisor_reg[11:8], wdata} : baud_divisor_reg),
    .reload       (wr_baud_l),
    .sync_mode    (sync_mode),
    .double_speed (double_speed_reg),
    .clk_pol      (ctrl_c_reg[CC_POL]),
    .run          (tx_active_reg || rx_en),
    .os_tick      (os_tick),
    .tx_tick      (tx_tick),
    .rx_edge      (rx_edge),
    .xck_reg      (sync_clock_pin)
  );

  spfb_rx u_rx (
    .core_clk (core_clk),
    .rstn     (rstn),
    .link     (rxl)
  );

  // Registers and read port
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_b_reg       <= CTRL_B_RST;
      ctrl_c_reg       <= CTRL_C_RST;
      baud_divisor_reg <= BAUD_RST;
      double_speed_reg <= 1'b0;
      rdata            <= 8'h00;
    end else begin
      rdata <= rd_stb ? rd_mux : 8'h00;
      if (wr_ctrl_b) ctrl_b_reg <= {wdata[7:2], 1'b0, wdata[0]}; // [RQ8]
      if (wr_ctrl_c) ctrl_c_reg <= {1'b0, wdata[6:0]};
      // Reserved upper nibble is dropped; software is expected to write it zero
      if (wr_baud_h) baud_divisor_reg[11:8] <= wdata[3:0]; // [RQ15] [RQ18]
      if (wr_baud_l) baud_divisor_reg[7:0] <= wdata; // [RQ15]
      if (wr_stat) double_speed_reg <= wdata[SA_DOUBLE]; // [RQ19]
    end
  end

  // Receive pin synchroniser and one-deep receive buffer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      rx_buf_reg  <= 9'h000;
      rx_full_reg <= 1'b0;
      fe_reg      <= 1'b0;
      ovr_reg     <= 1'b0;
      pe_reg      <= 1'b0;
    end else begin
      rx_s1_reg <= rxd_pin;
      rx_s2_reg <= rx_s1_reg;
      if (!rx_en) begin
        rx_full_reg <= 1'b0; // [RQ3]
        fe_reg      <= 1'b0; // [RQ3]
        ovr_reg     <= 1'b0; // [RQ3]
        pe_reg      <= 1'b0; // [RQ3]
      end else if (rxl.done) begin
        // A frame landing in the read cycle still takes the buffer
        if (rx_full_reg && !rd_data) begin
          ovr_reg <= 1'b1;
        end else begin
          rx_buf_reg  <= rxl.data;
          rx_full_reg <= 1'b1;
          fe_reg      <= rxl.fe;
          pe_reg      <= rxl.pe; // [RQ10]
          ovr_reg     <= 1'b0;
        end
      end else if (rd_data) begin
        rx_full_reg <= 1'b0;
        fe_reg      <= 1'b0;
        ovr_reg     <= 1'b0;
        pe_reg      <= 1'b0;
      end
    end
  end

  // Transmit buffer, shifter and pin ownership
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_buf_reg    <= 9'h000;
      tx_full_reg   <= 1'b0; // [RQ20]
      tx_sh_reg     <= 11'h7FF;
      tx_left_reg   <= 4'h0;
      tx_busy_reg   <= 1'b0;
      tx_active_reg <= 1'b0;
      tx_done_reg   <= 1'b0;
      txd_out       <= 1'b1;
      txd_oe        <= 1'b0;
    end else begin
      // Writes while the buffer is full are ignored
      if (wr_data && !tx_full_reg) begin
        tx_buf_reg  <= {ctrl_b_reg[CB_TX_NINTH], wdata}; // [RQ8]
        tx_full_reg <= 1'b1; // [RQ20]
      end else if (tx_load) begin
        tx_full_reg <= 1'b0; // [RQ20]
      end
      if (tx_load) begin
        txd_out     <= 1'b0;
        tx_sh_reg   <= {2'h3, tx_buf_reg | ~mask}; // [RQ10]
        tx_sh_reg[nbits] <= parity_mode[1] ? tx_par : 1'b1;
        tx_left_reg <= frame_len;
        tx_busy_reg <= 1'b1;
      end else if (tx_busy_reg && tx_tick) begin
        txd_out     <= tx_sh_reg[0];
        tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
        if (tx_end) tx_busy_reg <= 1'b0;
      end else if (!tx_busy_reg && tx_tick) begin
        txd_out <= 1'b1;
      end
      // Set wins over the write-one clear
      if (tx_end && !tx_full_reg) begin
        tx_done_reg <= 1'b1;
      end else if (wr_stat && wdata[SA_TX_DONE]) begin
        tx_done_reg <= 1'b0;
      end
      // Disabling waits for shifter and buffer to drain
      tx_active_reg <= tx_en || tx_busy_reg || tx_full_reg; // [RQ4] [RQ5]
      txd_oe        <= tx_active_reg; // [RQ4] [RQ5]
    end
  end

  // Pin takeover, synchronous clock and interrupt outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_pin_owned       <= 1'b0;
      sync_clock_pin_out <= 1'b0;
      sync_clock_pin_oe  <= 1'b0;
      tx_empty_irq       <= 1'b0;
    end else begin
      rx_pin_owned       <= rx_en; // [RQ2]
      sync_clock_pin_out <= sync_clock_pin; // [RQ13]
      sync_clock_pin_oe  <= sync_mode && (tx_active_reg || rx_en); // [RQ9]
      tx_empty_irq <= ctrl_b_reg[CB_TX_IRQ_EN] && global_irq_enable && !tx_full_reg; // [RQ1]
    end
  end
endmodule // spfb_top

/* tb/spfb_asserts.sv */
// Port-level checks for the serial port control block
`timescale 1ns/1ps
module spfb_asserts
  import spfb_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       global_irq_enable,
  input wire logic       tx_empty_irq,
  input wire logic       rxd_pin,
  input wire logic       rx_pin_owned,
  input wire logic       txd_out,
  input wire logic       txd_oe,
  input wire logic       sync_clock_pin_out,
  input wire logic       sync_clock_pin_oe
);
  logic [7:0] cb_reg;
  logic [7:0] cc_reg;
  wire        wr_b = wr_stb && addr == ADDR_CTRL_B;
  wire        wr_c = wr_stb && addr == ADDR_CTRL_C;
  // Shadow copies rebuilt from bus writes, so no internal probes are needed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cb_reg <= CTRL_B_RST;
      cc_reg <= CTRL_C_RST;
    end else begin
      cb_reg <= wr_b ? wdata : cb_reg;
      cc_reg <= wr_c ? wdata : cc_reg;
    end
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_rd_idle_zero: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_ctrl_b_read: assert property (rd_stb && addr == ADDR_CTRL_B |=>
    {rdata[7:2], rdata[0]} == {cb_reg[7:2], cb_reg[0]}) else $error("control b readback");
  a_ctrl_c_read: assert property (rd_stb && addr == ADDR_CTRL_C |=>
    rdata == {1'b0, cc_reg[6:0]}) else $error("control c readback");
  a_baud_hi_zero: assert property (rd_stb && addr == ADDR_BAUD_H |=>
    rdata[7:4] == 4'h0) else $error("baud high upper nibble set");
  a_rx_pin_take: assert property (rx_pin_owned == $past(cb_reg[CB_RX_EN]))
    else $error("receive pin ownership");
  a_tx_pin_take: assert property (cb_reg[CB_TX_EN] |-> ##2 txd_oe)
    else $error("transmit pin not owned");
  a_tx_drain: assert property ($fell(txd_oe) |->
    !$past(cb_reg[CB_TX_EN]) && $past(txd_out)) else $error("transmit pin dropped early");
  a_irq_gate: assert property (tx_empty_irq |->
    $past(cb_reg[CB_TX_IRQ_EN]) && $past(global_irq_enable)) else $error("empty irq ungated");
  a_sync_clk_off: assert property (!cc_reg[CC_SYNC] [*3] |->
    !sync_clock_pin_out && !sync_clock_pin_oe) else $error("sync clock in async mode");
  a_sync_edge: assert property (cc_reg[CC_SYNC] && $past(cc_reg[CC_SYNC]) && txd_oe &&
    $past(txd_oe) && txd_out != $past(txd_out) |-> sync_clock_pin_out !=
    $past(sync_clock_pin_out) && sync_clock_pin_out == !cc_reg[CC_POL])
    else $error("sync data changed on wrong edge");
  c_tx_owned: cover property ($rose(txd_oe));
  c_irq: cover property (tx_empty_irq);
  c_sync_clk: cover property ($rose(sync_clock_pin_out));
endmodule // spfb_asserts

bind spfb_top spfb_asserts i_spfb_asserts (
  .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .global_irq_enable(global_irq_enable),
  .tx_empty_irq(tx_empty_irq), .rxd_pin(rxd_pin), .rx_pin_owned(rx_pin_owned),
  .txd_out(txd_out), .txd_oe(txd_oe), .sync_clock_pin_out(sync_clock_pin_out),
  .sync_clock_pin_oe(sync_clock_pin_oe)
);

/* tb/spfb_remote.sv */
// Remote serial node: decodes transmitted frames and sends receive frames
`timescale 1ns/1ps
module spfb_remote (
  input  wire logic   core_clk,
  input  wire logic   txd,
  input  wire logic   txd_oe,
  output logic        rxd,
  output logic        got_valid,
  output logic [9:0]  got_word,
  output logic        gap_valid,
  output logic [15:0] gap
);
  int         bclk = 32;
  int         nbits = 8;
  logic [1:0] par = 2'h0;
  logic       on = 1'b0;
  int         cyc = 0;
  int         last_st = -100000;
  int         st;
  logic [9:0] w;
  initial begin
    rxd = 1'b1;
    got_valid = 1'b0;
    gap_valid = 1'b0;
    got_word = 10'h000;
    gap = 16'h0000;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  // Start-to-start spacing is only reported for frames sent back to back
  initial begin
    forever begin
      @(posedge core_clk iff (on && txd_oe && txd === 1'b0));
      st = cyc;
      if (st - last_st <= 13 * bclk) begin
        gap <= 16'(st - last_st);
        gap_valid <= 1'b1;
      end
      last_st = st;
      w = 10'h000;
      @(posedge core_clk);
      gap_valid <= 1'b0;
      repeat (bclk / 2 - 1) @(posedge core_clk);
      for (int i = 0; i < nbits; i++) begin
        repeat (bclk) @(posedge core_clk);
        w[i] = txd;
      end
      if (par[1]) begin
        repeat (bclk) @(posedge core_clk);
        w[9] = txd;
      end
      repeat (bclk) @(posedge core_clk);
      got_word <= w;
      got_valid <= txd;
      @(posedge core_clk);
      got_valid <= 1'b0;
    end
  end
  // Idle line rests at the stop level; flip inverts the parity bit
  task automatic send(input logic [8:0] d, input logic flip);
    logic p;
    p = ^(d & 9'((1 << nbits) - 1)) ^ par[0] ^ flip;
    rxd <= 1'b0;
    repeat (bclk) @(posedge core_clk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= d[i];
      repeat (bclk) @(posedge core_clk);
    end
    if (par[1]) begin
      rxd <= p;
      repeat (bclk) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (bclk) @(posedge core_clk);
  endtask
endmodule // spfb_remote

/* tb/serial_port_frame_and_baud_control_test.sv */
// Self-checking bench for the serial port frame and baud control block
`timescale 1ns/1ps
module serial_port_frame_and_baud_control_test;
  import spfb_pkg::*;
  localparam int DIV = 1;
  localparam int LIMIT = 40000;
  localparam logic [2:0] SZ [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h3};
  localparam int NB [7] = '{5, 6, 7, 8, 9, 8, 8};
  localparam logic [1:0] PM [7] = '{2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h0, 2'h2};
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        global_irq_enable = 1'b0;
  logic        rd_seen = 1'b0;
  logic [7:0]  rdata;
  logic        irq, owned, txd, txd_oe, sync_clock_pin, xck_oe, rxd, got_valid, gap_valid;
  logic [9:0]  got_word;
  logic [15:0] gap;
  logic [15:0] rq[$];
  logic [15:0] re;
  logic [9:0]  wq[$];
  logic [15:0] gq[$];
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  spfb_top i_spfb_top (.core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .global_irq_enable(global_irq_enable),
    .tx_empty_irq(irq), .rxd_pin(rxd), .rx_pin_owned(owned), .txd_out(txd), .txd_oe(txd_oe),
    .sync_clock_pin_out(sync_clock_pin), .sync_clock_pin_oe(xck_oe));
  spfb_remote i_spfb_remote (.core_clk(core_clk), .txd(txd), .txd_oe(txd_oe), .rxd(rxd),
    .got_valid(got_valid), .got_word(got_word), .gap_valid(gap_valid), .gap(gap));
  always #4 core_clk = ~core_clk;
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Strobes drop for one cycle between accesses so no signal is driven twice at one edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e,
                    output logic [7:0] v);
    rq.push_back({m, e});
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] v;
    rd(a, m, e, v);
  endtask
  task automatic poll(input logic [2:0] a, input int b, input logic val);
    logic [7:0] v;
    for (int k = 0; k < 2000; k++) begin
      rd(a, 8'h00, 8'h00, v);
      if (v[b] === val) break;
    end
    cmp(16'(v[b]), 16'(val));
  endtask
  always @(posedge core_clk) rd_seen <= rd_stb;
  always @(negedge core_clk) begin
    if (rd_seen && rq.size() > 0) begin
      re = rq.pop_front();
      if (re[15:8] != 8'h00) cmp(16'(rdata & re[15:8]), 16'(re[7:0]));
    end
    if (got_valid) cmp(16'(got_word), wq.size() > 0 ? 16'(wq.pop_front()) : 16'hFFFF);
    if (gap_valid) cmp(gap, gq.size() > 0 ? gq.pop_front() : 16'hFFFF);
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    logic [8:0] d;
    int bc;
    int nb;
    void'($urandom(68660));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(ADDR_STAT_A, 8'h20, 8'hFF);
    chk(ADDR_CTRL_B, 8'h00, 8'hFF);
    chk(ADDR_CTRL_C, 8'h06, 8'hFF);
    chk(3'h6, 8'h00, 8'hFF);
    wr(ADDR_BAUD_H, 8'h0A);
    chk(ADDR_BAUD_H, 8'h0A, 8'hFF);
    wr(ADDR_BAUD_H, 8'h00);
    wr(ADDR_BAUD_L, 8'(DIV));
    chk(ADDR_BAUD_L, 8'(DIV), 8'hFF);
    for (int k = 0; k < 7; k++) begin
      bc = (k == 6 ? 8 : 16) * (DIV + 1);
      nb = NB[k];
      wr(ADDR_STAT_A, {6'h00, k == 6, 1'b0});
      wr(ADDR_CTRL_C, {2'b00, PM[k], k[0], SZ[k][1:0], 1'b0});
      i_spfb_remote.bclk = bc;
      i_spfb_remote.nbits = nb;
      i_spfb_remote.par = PM[k];
      i_spfb_remote.on = 1'b1;
      for (int j = 0; j < 2; j++) begin
        d = 9'($urandom);
        wr(ADDR_CTRL_B, {4'h0, 1'b1, SZ[k][2], 1'b0, d[8]});
        poll(ADDR_STAT_A, SA_TX_EMPTY, 1'b1);
        wr(ADDR_DATA, d[7:0]);
        d = d & 9'((1 << nb) - 1);
        wq.push_back({PM[k][1] & (^d ^ PM[k][0]), d});
      end
      chk(ADDR_STAT_A, 8'h00, 8'h20);
      wr(ADDR_DATA, 8'hFF);
      gq.push_back(16'(bc * (2 + nb + PM[k][1] + k[0])));
      repeat (30 * bc) @(posedge core_clk);
    end
    wr(ADDR_STAT_A, 8'h00);
    i_spfb_remote.on = 1'b0;
    wr(ADDR_CTRL_C, 8'h26);
    wr(ADDR_CTRL_B, 8'h14);
    i_spfb_remote.bclk = 16 * (DIV + 1);
    i_spfb_remote.nbits = 9;
    i_spfb_remote.par = 2'h2;
    d = 9'($urandom);
    i_spfb_remote.send(d, 1'b0);
    poll(ADDR_STAT_A, SA_RX_DONE, 1'b1);
    chk(ADDR_CTRL_B, {6'h00, d[8], 1'b0}, 8'h02);
    chk(ADDR_DATA, d[7:0], 8'hFF);
    i_spfb_remote.send(~d, 1'b1);
    poll(ADDR_STAT_A, SA_RX_DONE, 1'b1);
    chk(ADDR_STAT_A, 8'h84, 8'h9C);
    i_spfb_remote.send(d, 1'b0);
    repeat (8) @(posedge core_clk);
    chk(ADDR_STAT_A, 8'h08, 8'h08);
    wr(ADDR_CTRL_B, 8'h04);
    chk(ADDR_STAT_A, 8'h00, 8'h9C);
    wr(ADDR_CTRL_B, 8'h2C);
    #1 cmp(16'(irq), 16'h0000);
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 cmp(16'(irq), 16'h0001);
    i_spfb_remote.on = 1'b1;
    d = 9'($urandom) & 9'h0FF;
    wr(ADDR_DATA, d[7:0]);
    wq.push_back({^d, d});
    wr(ADDR_CTRL_B, 8'h24);
    #1 cmp(16'(txd_oe), 16'h0001);
    repeat (20 * 16 * (DIV + 1)) @(posedge core_clk);
    #1 cmp(16'(txd_oe), 16'h0000);
    i_spfb_remote.on = 1'b0;
    // Polarity is only moved while the transmitter is off, so no edge is half done
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL_C, {2'b01, 4'h0, 1'b1, k[0]});
      wr(ADDR_CTRL_B, 8'h08);
      wr(ADDR_DATA, 8'($urandom));
      repeat (200) @(posedge core_clk);
      wr(ADDR_CTRL_B, 8'h00);
    end
    wr(ADDR_CTRL_C, 8'h06);
    repeat (10) @(posedge core_clk);
    results();
  end
endmodule // serial_port_frame_and_baud_control_test
